// file: verilog/tx_status_pkg.sv
// constants for the transmit status and converter read-back register group
package tx_status_pkg;

    // =========================================================
    // widths
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;
    localparam int ADC_W    = 10;
    localparam int ADC_LO_W = 2;
    localparam int LF_W     = 3;
    localparam int OHMS_W   = 10;

    // =========================================================
    // register numbers, used directly as the register address
    localparam logic [7:0] REG_ADC_HIGH    = 8'h28;
    localparam logic [7:0] REG_ADC_LOW     = 8'h29;
    localparam logic [7:0] REG_TX_STATUS   = 8'h2b;
    localparam logic [7:0] RSVD_A_FIRST    = 8'h2c;
    localparam logic [7:0] RSVD_A_LAST     = 8'h32;
    localparam logic [7:0] REG_LOOP_FILTER = 8'h33;
    localparam logic [7:0] RSVD_B_FIRST    = 8'h34;
    localparam logic [7:0] RSVD_B_LAST     = 8'h37;

    // =========================================================
    // field positions
    localparam int STAT_UNLOCK_BIT = 7;
    localparam int STAT_LATCH_BIT  = 6;
    localparam int STAT_FAULT_BIT  = 5;
    localparam int STAT_DRVDIS_BIT = 4;
    localparam int LF_SEL_HI       = 7;
    localparam int LF_SEL_LO       = 5;

    // =========================================================
    // reset values and scaling
    localparam logic [7:0]  DATA_ZERO    = 8'h00;
    localparam logic [7:0]  LF_RESET     = 8'h40;
    localparam logic [2:0]  LF_SEL_RESET = 3'h2;
    localparam logic [9:0]  LF_STEP_OHMS = 10'h04b;
    localparam logic [9:0]  ADC_RESET    = 10'h000;

endpackage

// file: verilog/status_if.sv
// carrier between the status capture and the register bank
`timescale 1ns/1ns
interface status_if;
    logic lock_raw;
    logic lock_latched;
    logic fault;
    logic drvdis;
    logic read_clear;

    modport capture (
        output lock_raw,
        output lock_latched,
        output fault,
        output drvdis,
        input  read_clear
    );
    modport regs (
        input  lock_raw,
        input  lock_latched,
        input  fault,
        input  drvdis,
        output read_clear
    );
endinterface

// file: verilog/status_capture.sv
// synchronisers for the status pins and the latched-low lock bit
`timescale 1ns/1ns
module status_capture (
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire logic     recovery_unlocked_pin,
    input  wire logic     transmit_fault_pin,
    input  wire logic     driver_disabled_pin,
    status_if.capture     st
);

    // =========================================================
    // pin synchronisers
    logic [2:0] pins;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       lock_latched_r;

    assign pins = {driver_disabled_pin, transmit_fault_pin, recovery_unlocked_pin};

    // two stages; first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    assign st.lock_raw = sync2_r[0];
    assign st.fault    = sync2_r[1];
    assign st.drvdis   = sync2_r[2];

    // =========================================================
    // latched-low copy of the raw lock bit
    // a low raw bit beats a read clear in the same cycle, so no dip is lost
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lock_latched_r <= 1'b0;
        end else begin
            lock_latched_r <= sync2_r[0] & (st.read_clear | lock_latched_r);
        end
    end

    assign st.lock_latched = lock_latched_r;

    // =========================================================
    // checks
    a_latch_goes_low: assert property (@(posedge mclk) disable iff (!rst_n)
        !st.lock_raw |=> !st.lock_latched)
        else $error("latched lock bit missed a low raw level");

    a_latch_stays_low: assert property (@(posedge mclk) disable iff (!rst_n)
        (!st.lock_latched && !st.read_clear) |=> !st.lock_latched)
        else $error("latched lock bit rose without a read");

    a_latch_rearms: assert property (@(posedge mclk) disable iff (!rst_n)
        (st.read_clear && st.lock_raw) |=> st.lock_latched)
        else $error("read did not re-arm latched lock bit");

    a_sync_two_stage: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && $past(rst_n, 2)) |-> (st.fault == $past(transmit_fault_pin, 2)))
        else $error("fault flag not two cycles behind its pin");

endmodule

// file: verilog/tx_status_regs.sv
// register bank: converter read-back, transmit status, loop filter adjust
// How it works
// - the 10-bit converter result reads as bits 9:2 in register 40 and bits 1:0 in register 41.
// - status bit 7 reads 1 while clock recovery is unlocked and 0 while locked.
// - status bit 6 drops to 0 when the raw lock bit goes low and stays there.
// - reading the status register re-arms bit 6 to follow the raw lock bit again.
// - status bit 5 reads 1 while a transmit fault is present.
// - status bit 4 reads 1 while the fault logic holds the driver disabled.
// - bits 7:5 of register 51 pick the loop filter resistance, 75 ohms per step plus 75.
// - register 51 resets to 40h, code 010 and zero low bits.
// - registers 44 to 50 are read-only and read zero.
// - registers 52 to 55 are read-only and read zero.
`timescale 1ns/1ns
module tx_status_regs (
    input  wire logic                               mclk,
    input  wire logic                               rst_n,
    input  wire logic [tx_status_pkg::ADC_W-1:0]    converter_result,
    input  wire logic                               recovery_unlocked_pin,
    input  wire logic                               transmit_fault_pin,
    input  wire logic                               driver_disabled_pin,
    input  wire logic [tx_status_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic                               reg_wr_en,
    input  wire logic [tx_status_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                               reg_rd_en,
    output logic      [tx_status_pkg::DATA_W-1:0]   reg_rdata,
    output logic                                    reg_rd_valid,
    output logic      [tx_status_pkg::LF_W-1:0]     loop_filter_sel,
    output logic      [tx_status_pkg::OHMS_W-1:0]   loop_filter_ohms
);

    // =========================================================
    // helpers
    function automatic logic in_range(
        input logic [7:0] a,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // resistance in ohms for a selector code
    function automatic logic [9:0] ohms_of(input logic [2:0] code);
        logic [9:0] steps;
        steps   = {7'h00, code} + 10'h001;
        ohms_of = 10'(steps * tx_status_pkg::LF_STEP_OHMS);
    endfunction

    // =========================================================
    // status capture
    status_if st ();

    status_capture u_capture (
        .mclk                  (mclk),
        .rst_n                 (rst_n),
        .recovery_unlocked_pin (recovery_unlocked_pin),
        .transmit_fault_pin    (transmit_fault_pin),
        .driver_disabled_pin   (driver_disabled_pin),
        .st                    (st)
    );

    // =========================================================
    // decode
    logic rd_adc_high;
    logic rd_adc_low;
    logic rd_status;
    logic rd_lf;
    logic rd_rsvd;
    logic wr_lf;

    assign rd_adc_high = reg_rd_en && (reg_addr == tx_status_pkg::REG_ADC_HIGH);
    assign rd_adc_low  = reg_rd_en && (reg_addr == tx_status_pkg::REG_ADC_LOW);
    assign rd_status   = reg_rd_en && (reg_addr == tx_status_pkg::REG_TX_STATUS);
    assign rd_lf       = reg_rd_en && (reg_addr == tx_status_pkg::REG_LOOP_FILTER);
    assign rd_rsvd     = reg_rd_en &&
        (in_range(reg_addr, tx_status_pkg::RSVD_A_FIRST, tx_status_pkg::RSVD_A_LAST) ||
         in_range(reg_addr, tx_status_pkg::RSVD_B_FIRST, tx_status_pkg::RSVD_B_LAST));
    assign wr_lf       = reg_wr_en && (reg_addr == tx_status_pkg::REG_LOOP_FILTER);

    // only the status read clears anything
    assign st.read_clear = rd_status;

    // =========================================================
    // loop filter adjust, only the selector field is kept
    // reserved low bits are not stored, which saves flops and keeps them zero
    logic [tx_status_pkg::LF_W-1:0] lf_sel_r;
    logic [tx_status_pkg::LF_W-1:0] lf_sel_nxt;

    always_comb begin
        lf_sel_nxt = lf_sel_r;
        if (wr_lf) begin
            lf_sel_nxt = reg_wdata[tx_status_pkg::LF_SEL_HI:tx_status_pkg::LF_SEL_LO];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lf_sel_r <= tx_status_pkg::LF_RESET[tx_status_pkg::LF_SEL_HI:tx_status_pkg::LF_SEL_LO];
        end else begin
            lf_sel_r <= lf_sel_nxt;
        end
    end

    assign loop_filter_sel = lf_sel_r;

    // resistance follows the selector with no extra lag
    logic [tx_status_pkg::OHMS_W-1:0] ohms_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ohms_r <= ohms_of(tx_status_pkg::LF_SEL_RESET);
        end else begin
            ohms_r <= ohms_of(lf_sel_nxt);
        end
    end

    assign loop_filter_ohms = ohms_r;

    // =========================================================
    // read data mux
    logic [tx_status_pkg::DATA_W-1:0] rdata_nxt;
    logic [tx_status_pkg::DATA_W-1:0] rdata_r;
    logic                             rd_valid_r;

    always_comb begin
        rdata_nxt = tx_status_pkg::DATA_ZERO;
        if (rd_adc_high) begin
            rdata_nxt = converter_result[tx_status_pkg::ADC_W-1:tx_status_pkg::ADC_LO_W];
        end else if (rd_adc_low) begin
            rdata_nxt[tx_status_pkg::ADC_LO_W-1:0] =
                converter_result[tx_status_pkg::ADC_LO_W-1:0];
        end else if (rd_status) begin
            rdata_nxt[tx_status_pkg::STAT_UNLOCK_BIT] = st.lock_raw;
            rdata_nxt[tx_status_pkg::STAT_LATCH_BIT]  = st.lock_latched;
            rdata_nxt[tx_status_pkg::STAT_FAULT_BIT]  = st.fault;
            rdata_nxt[tx_status_pkg::STAT_DRVDIS_BIT] = st.drvdis;
        end else if (rd_lf) begin
            rdata_nxt[tx_status_pkg::LF_SEL_HI:tx_status_pkg::LF_SEL_LO] = lf_sel_r;
        end else if (rd_rsvd) begin
            rdata_nxt = tx_status_pkg::DATA_ZERO;
        end
    end

    // read data held until the next read; unmapped reads answer zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_r <= tx_status_pkg::DATA_ZERO;
        end else if (reg_rd_en) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
        end
    end

    assign reg_rdata    = rdata_r;
    assign reg_rd_valid = rd_valid_r;

    // =========================================================
    // checks
    a_adc_high_read: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_adc_high |=> (reg_rdata == $past(converter_result[9:2])))
        else $error("converter high byte read wrong");

    a_adc_low_read: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_adc_low |=> (reg_rdata == {6'h00, $past(converter_result[1:0])}))
        else $error("converter low bits read wrong");

    a_status_live_bits: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_status |=> (reg_rdata[7] == $past(st.lock_raw)) &&
                      (reg_rdata[5] == $past(st.fault)) &&
                      (reg_rdata[4] == $past(st.drvdis)) &&
                      (reg_rdata[3:0] == 4'h0))
        else $error("status live bits read wrong");

    a_status_latch_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_status && !st.lock_latched) |=> !reg_rdata[6])
        else $error("latched lock bit read high while latched low");

    a_rsvd_a_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd_en && reg_addr >= 8'h2c && reg_addr <= 8'h32) |=> (reg_rdata == 8'h00))
        else $error("reserved block a read nonzero");

    a_rsvd_b_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd_en && reg_addr >= 8'h34 && reg_addr <= 8'h37) |=> (reg_rdata == 8'h00))
        else $error("reserved block b read nonzero");

    a_lf_reset_value: assert property (@(posedge mclk)
        !rst_n |=> (loop_filter_sel == 3'h2) && (loop_filter_ohms == 10'h0e1))
        else $error("loop filter not at default after reset");

    a_lf_write_take: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_lf |=> (loop_filter_sel == $past(reg_wdata[7:5])))
        else $error("loop filter write not taken");

    // a read in the write cycle still returns the old selector
    a_lf_read_back: assert property (@(posedge mclk) disable iff (!rst_n)
        rd_lf |=> (reg_rdata == {$past(loop_filter_sel), 5'h00}))
        else $error("loop filter read back wrong");

    a_status_latch_high: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_status && st.lock_latched) |=> reg_rdata[6])
        else $error("latched lock bit read low while armed");

    a_unmapped_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd_en && reg_addr == 8'h2a) |=> (reg_rdata == 8'h00))
        else $error("unmapped register read nonzero");

    // read data must not drift between reads
    a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !reg_rd_en |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    a_valid_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rst_n) |-> (reg_rd_valid == $past(reg_rd_en)))
        else $error("read valid not one cycle after the strobe");

    a_ohms_scale: assert property (@(posedge mclk) disable iff (!rst_n)
        loop_filter_ohms == 10'((loop_filter_sel + 10'h001) * 10'h04b))
        else $error("loop filter resistance out of step");

    a_ro_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_wr_en && reg_addr != 8'h33) |=> $stable(loop_filter_sel))
        else $error("write to read-only register changed state");

    a_no_side_effect: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd_en && reg_addr != 8'h2b && !st.lock_latched) |=> !st.lock_latched)
        else $error("non-status read cleared the latched bit");

endmodule

// file: bench/test_tx_status_regs.sv
// self-checking bench for the transmit status and converter read-back registers
`timescale 1ns/1ns
module test_tx_status_regs;

    // =========================================================
    // stimulus and observation signals
    logic       mclk;
    logic       rst_n;
    logic [9:0] converter_result;
    logic       recovery_unlocked_pin;
    logic       transmit_fault_pin;
    logic       driver_disabled_pin;
    logic [7:0] reg_addr;
    logic       reg_wr_en;
    logic [7:0] reg_wdata;
    logic       reg_rd_en;
    logic [7:0] reg_rdata;
    logic       reg_rd_valid;
    logic [2:0] loop_filter_sel;
    logic [9:0] loop_filter_ohms;
    int         failures;
    int         samples_checked;
    int         cycles;

    tx_status_regs i_tx_status_regs (
        .mclk                  (mclk),
        .rst_n                 (rst_n),
        .converter_result      (converter_result),
        .recovery_unlocked_pin (recovery_unlocked_pin),
        .transmit_fault_pin    (transmit_fault_pin),
        .driver_disabled_pin   (driver_disabled_pin),
        .reg_addr              (reg_addr),
        .reg_wr_en             (reg_wr_en),
        .reg_wdata             (reg_wdata),
        .reg_rd_en             (reg_rd_en),
        .reg_rdata             (reg_rdata),
        .reg_rd_valid          (reg_rd_valid),
        .loop_filter_sel       (loop_filter_sel),
        .loop_filter_ohms      (loop_filter_ohms)
    );

    // =========================================================
    // 20 MHz clock and hang guard
    always #25 mclk = ~mclk;

    // the whole run needs about 125 cycles, so 3000 means a hang
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            finish_test();
        end
    end

    // =========================================================
    // shared tasks
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // strobe held for exactly one taking edge, data looked at 1 ns after that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge mclk);
        reg_rd_en <= 1'b0;
        #1;
        check("read valid", {9'h000, reg_rd_valid}, 10'h001);
        d = reg_rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr_en <= 1'b1;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        #1;
    endtask

    // status pins are synchronised, so give them a few cycles to land
    task automatic set_pins(input logic unl, input logic flt, input logic dis);
        @(posedge mclk);
        recovery_unlocked_pin <= unl;
        transmit_fault_pin    <= flt;
        driver_disabled_pin   <= dis;
        repeat (4) @(posedge mclk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // =========================================================
    // scenarios
    task automatic test_reset_values();
        logic [7:0] d;
        check("sel after reset", {7'h00, loop_filter_sel}, 10'h002);
        check("ohms after reset", loop_filter_ohms, 10'h0e1);
        rd(tx_status_pkg::REG_LOOP_FILTER, d);
        check("adjust after reset", {2'h0, d}, 10'h040);
    endtask

    task automatic test_converter();
        logic [7:0] d;
        @(posedge mclk);
        converter_result <= 10'h2b5;
        rd(tx_status_pkg::REG_ADC_HIGH, d);
        check("converter high", {2'h0, d}, 10'h0ad);
        rd(tx_status_pkg::REG_ADC_LOW, d);
        check("converter low", {2'h0, d}, 10'h001);
    endtask

    // latch starts at 0 and follows the raw bit only after a status read
    task automatic test_status();
        logic [7:0] d;
        set_pins(1'b1, 1'b1, 1'b0);
        rd(tx_status_pkg::REG_TX_STATUS, d);
        check("status unlocked fault", {2'h0, d}, 10'h0a0);
        rd(tx_status_pkg::REG_TX_STATUS, d);
        check("status re-armed", {2'h0, d}, 10'h0e0);
        set_pins(1'b0, 1'b0, 1'b1);
        set_pins(1'b1, 1'b0, 1'b1);
        rd(tx_status_pkg::REG_ADC_HIGH, d);
        rd(tx_status_pkg::REG_TX_STATUS, d);
        check("status latched low", {2'h0, d}, 10'h090);
        rd(tx_status_pkg::REG_TX_STATUS, d);
        check("status cleared by read", {2'h0, d}, 10'h0d0);
        set_pins(1'b0, 1'b0, 1'b0);
        rd(tx_status_pkg::REG_TX_STATUS, d);
        check("status locked", {2'h0, d}, 10'h000);
    endtask

    task automatic test_loop_filter();
        logic [7:0] d;
        logic [2:0] code;
        for (int i = 0; i < 8; i++) begin
            code = 3'(i);
            wr(tx_status_pkg::REG_LOOP_FILTER, {code, 5'h1f});
            check("sel code", {7'h00, loop_filter_sel}, {7'h00, code});
            check("ohms", loop_filter_ohms, 10'((i + 1) * 75));
            rd(tx_status_pkg::REG_LOOP_FILTER, d);
            check("adjust readback", {2'h0, d}, {2'h0, code, 5'h00});
        end
    endtask

    // writes to read-only places must not land anywhere
    task automatic test_reserved();
        logic [7:0] d;
        wr(8'h2c, 8'hff);
        wr(8'h37, 8'hff);
        wr(tx_status_pkg::REG_ADC_HIGH, 8'h00);
        check("sel untouched", {7'h00, loop_filter_sel}, 10'h007);
        for (int a = 8'h2a; a <= 8'h37; a++) begin
            if (a != 8'h2b && a != 8'h33) begin
                rd(8'(a), d);
                check("reserved reads zero", {2'h0, d}, 10'h000);
            end
        end
        rd(tx_status_pkg::REG_ADC_HIGH, d);
        check("converter still read-only", {2'h0, d}, 10'h0ad);
    endtask

    // a reset in mid-run must bring the adjust register back to default
    task automatic test_mid_reset();
        logic [7:0] d;
        wr(tx_status_pkg::REG_LOOP_FILTER, 8'ha0);
        check("sel before mid reset", {7'h00, loop_filter_sel}, 10'h005);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check("sel after mid reset", {7'h00, loop_filter_sel}, 10'h002);
        check("ohms after mid reset", loop_filter_ohms, 10'h0e1);
        rd(tx_status_pkg::REG_LOOP_FILTER, d);
        check("adjust after mid reset", {2'h0, d}, 10'h040);
        rd(tx_status_pkg::REG_TX_STATUS, d);
        check("status after mid reset", {2'h0, d}, 10'h000);
    endtask

    // =========================================================
    // main sequence
    initial begin
        mclk                  = 1'b0;
        rst_n                 = 1'b0;
        converter_result      = 10'h000;
        recovery_unlocked_pin = 1'b0;
        transmit_fault_pin    = 1'b0;
        driver_disabled_pin   = 1'b0;
        reg_addr              = 8'h00;
        reg_wr_en             = 1'b0;
        reg_wdata             = 8'h00;
        reg_rd_en             = 1'b0;
        failures              = 0;
        samples_checked       = 0;
        cycles                = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check("valid idle", {9'h000, reg_rd_valid}, 10'h000);
        test_reset_values();
        test_converter();
        test_status();
        test_loop_filter();
        test_reserved();
        test_mid_reset();
        finish_test();
    end

endmodule
